// ### bench/test_transceiver_command_register_bank.sv
/*
 * Self-checking bench of the command register bank.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module test_transceiver_command_register_bank;
    localparam logic [15:0] DEF [14] = '{`RST_AFADJ, `RST_TXMOD, `RST_TXBYTE, `RST_FREQ,
        `RST_RXCTL, `RST_BBAND, `RST_BUFRST, `RST_SYNC, `RST_RATE, `RST_POWER, `RST_WAKE,
        `RST_DUTY, `RST_SUPPLY, `RST_SYNTH};
    localparam logic [15:0] MSK [14] = '{`MSK_AFADJ, `MSK_TXMOD, `MSK_TXBYTE, `MSK_FREQ,
        `MSK_RXCTL, `MSK_BBAND, `MSK_BUFRST, `MSK_SYNC, `MSK_RATE, `MSK_POWER, `MSK_WAKE,
        `MSK_DUTY, `MSK_SUPPLY, `MSK_SYNTH};
    logic clk_sys, sys_rst, ext_int_n, txrx_event, overrun_event, wake_event, afc_done;
    logic supply_low, rx_empty, signal_level, good_quality, clock_lock, offset_sign_in;
    logic rx_data_raw, rx_clk_raw, tx_data_path_enable, rx_buffer_enable, band_valid;
    logic spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, tx_byte_load, rx_buffer_read;
    logic data_pin_out, data_pin_oe, rclk_pin_out, rclk_pin_oe;
    logic [3:0] offset_magnitude_in, crystal_load_select;
    logic [1:0] band_select;
    logic [7:0] crystal_load_tenths;
    logic [15:0] status_word;
    logic [15:0] regs [14];
    int n_fail, n_compared, n_txl, n_rxr, cyc;

    xcvr_spi_host i_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo));
    transceiver_command_register_bank i_transceiver_command_register_bank (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ext_int_n(ext_int_n),
        .txrx_event(txrx_event), .overrun_event(overrun_event), .wake_event(wake_event),
        .afc_done(afc_done), .supply_low(supply_low), .rx_empty(rx_empty),
        .signal_level(signal_level), .good_quality(good_quality), .clock_lock(clock_lock),
        .offset_sign_in(offset_sign_in), .offset_magnitude_in(offset_magnitude_in),
        .rx_data_raw(rx_data_raw), .rx_clk_raw(rx_clk_raw), .status_word(status_word),
        .tx_data_path_enable(tx_data_path_enable), .rx_buffer_enable(rx_buffer_enable),
        .band_select(band_select), .band_valid(band_valid),
        .crystal_load_select(crystal_load_select), .crystal_load_tenths(crystal_load_tenths),
        .freq_offset_adjust(regs[0]), .transmit_modulation_setup(regs[1]),
        .transmit_byte_write(regs[2]), .carrier_frequency_word(regs[3]),
        .receiver_control(regs[4]), .baseband_filter_setup(regs[5]),
        .buffer_and_reset_setup(regs[6]), .sync_pattern_byte(regs[7]),
        .bit_rate_setup(regs[8]), .power_block_enables(regs[9]), .wake_timer_period(regs[10]),
        .wake_duty_cycle(regs[11]), .supply_threshold_clock_div(regs[12]),
        .synthesizer_setup(regs[13]), .tx_byte_load(tx_byte_load),
        .rx_buffer_read(rx_buffer_read), .data_pin_out(data_pin_out),
        .data_pin_oe(data_pin_oe), .rclk_pin_out(rclk_pin_out), .rclk_pin_oe(rclk_pin_oe));

    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // strobe counters and hang guard; a run needs fewer than a thousand cycles
    always @(posedge clk_sys) begin
        n_txl += int'(tx_byte_load);
        n_rxr += int'(rx_buffer_read);
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("[ERR] %0t run did not finish", $time);
            print_verdict();
        end
    end
    task print_verdict;
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] w);
        logic [16:0] g;
        i_host.xfer(16, {1'b0, w}, g);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic rd(output logic [15:0] s);
        logic [16:0] g;
        i_host.xfer(17, 17'h00000, g);
        s = g[15:0];
        repeat (2) @(negedge clk_sys);
    endtask
    task t_reset;
        for (int i = 0; i < 14; i++) chk(regs[i], DEF[i]);
        chk(16'({tx_data_path_enable, rx_buffer_enable, band_select, crystal_load_select}),
            16'h0008);
        chk(status_word, 16'h4000);
        chk(16'({crystal_load_tenths, band_valid, data_pin_oe, rclk_pin_oe}), 16'h3EB);
    endtask
    // every sticky source raised, the pin a cycle before the event pulses, then two reads and a buffer read
    task automatic t_status;
        logic [15:0] s, e;
        supply_low = 1'b1;
        rx_empty = 1'b1;
        signal_level = 1'b1;
        clock_lock = 1'b1;
        offset_sign_in = 1'b1;
        offset_magnitude_in = 4'hA;
        ext_int_n = 1'b0;
        @(negedge clk_sys);
        {wake_event, overrun_event, txrx_event, afc_done} = 4'hF;
        @(negedge clk_sys);
        {wake_event, overrun_event, txrx_event, afc_done} = 4'h0;
        repeat (6) @(negedge clk_sys);
        // bits 11..5: pin fall, low supply, empty, level, quality 0, lock, toggle
        e = {4'hF, 7'b1111011, 5'h1A};
        rd(s);
        chk(s, e);
        chk(status_word, {5'h10, e[10:0]});
        rd(s);
        chk(s, {5'h10, e[10:0]});
        ext_int_n = 1'b1;
        wr(16'hB000);
        chk(16'({status_word[15], 8'(n_rxr)}), 16'h0001);
    endtask
    // band codes, both buffer settings, crystal codes 0 and 15
    task automatic t_config;
        logic [15:0] w;
        for (int k = 0; k < 8; k++) begin
            w = {8'h80, k[2], ~k[2], k[1:0], k[2:0], k[0]};
            wr(w);
            chk(16'({tx_data_path_enable, rx_buffer_enable, band_select, crystal_load_select}),
                16'(w[7:0]));
            chk(16'(crystal_load_tenths), 16'(8'h55 + 8'h05 * w[3:0]));
            chk(16'({band_valid, data_pin_oe, rclk_pin_oe, data_pin_out, rclk_pin_out}),
                16'({|w[5:4], {4{k[2]}}}));
        end
    endtask
    // each word written with its code kept and all other bits flipped
    task automatic t_regs;
        int t0;
        for (int i = 0; i < 14; i++) begin
            t0 = n_txl;
            wr((DEF[i] & MSK[i]) | (~DEF[i] & ~MSK[i]));
            chk(regs[i], (DEF[i] & MSK[i]) | (~DEF[i] & ~MSK[i]));
            chk(16'(n_txl - t0), 16'(i == 2));
        end
    endtask
    // unknown code and wrong-length frames leave everything as it was
    task automatic t_refuse;
        logic [16:0] g;
        wr(16'h81FF);
        i_host.xfer(15, 17'h04000, g);
        i_host.xfer(17, 17'h10000, g);
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 14; i++) chk(regs[i], (DEF[i] & MSK[i]) | (~DEF[i] & ~MSK[i]));
        chk(16'({tx_data_path_enable, rx_buffer_enable, band_select, crystal_load_select}),
            16'h00BF);
    endtask
    // reset, then the scenarios in turn
    initial begin
        {n_fail, n_compared, n_txl, n_rxr, cyc} = '0;
        {txrx_event, overrun_event, wake_event, afc_done, supply_low, rx_empty} = '0;
        {signal_level, good_quality, clock_lock, offset_sign_in} = '0;
        offset_magnitude_in = 4'h0;
        rx_data_raw = 1'b1;
        rx_clk_raw = 1'b1;
        ext_int_n = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_status();
        t_config();
        t_regs();
        t_refuse();
        print_verdict();
    end
endmodule

// ### bench/transceiver_command_register_bank_checker.sv
/*
 * Port-level properties of the command register bank, clk_sys domain.
 * Assumes it is bound to the bank's top module by the bind at the foot.
 */
`timescale 1ns/1ps
module transceiver_command_register_bank_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe,
    input wire logic ext_int_n,
    input wire logic txrx_event,
    input wire logic overrun_event,
    input wire logic wake_event,
    input wire logic afc_done,
    input wire logic supply_low,
    input wire logic offset_sign_in,
    input wire logic [3:0] offset_magnitude_in,
    input wire logic [15:0] status_word,
    input wire logic [1:0] band_select,
    input wire logic band_valid,
    input wire logic [3:0] crystal_load_select,
    input wire logic [7:0] crystal_load_tenths,
    input wire logic rx_buffer_enable,
    input wire logic data_pin_oe,
    input wire logic data_pin_out,
    input wire logic tx_byte_load
);
    // one domain only, so clock and reset are stated once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_band_valid_code: assert property (band_valid == (band_select != 2'b00))
        else $error("band valid flag disagrees with band code");
    a_cap_tenths_scale: assert property (crystal_load_tenths == 8'h55 + 8'h05 * crystal_load_select)
        else $error("crystal load scale wrong");
    a_pin_oe_buffer: assert property (data_pin_oe == !rx_buffer_enable)
        else $error("data pin enable wrong");
    a_pin_quiet_off: assert property (!data_pin_oe |-> !data_pin_out)
        else $error("data pin driven while buffer on");
    a_por_on_release: assert property ($fell(sys_rst) |-> status_word[14])
        else $error("power-on flag missing after reset");
    a_overrun_sticky: assert property (overrun_event |=> status_word[13])
        else $error("overrun flag not set");
    a_wake_sticky: assert property (wake_event |=> status_word[12])
        else $error("wake flag not set");
    a_txrx_sticky: assert property (txrx_event |=> status_word[15])
        else $error("tx ready flag not set");
    a_pin_fall_flag: assert property ($fell(ext_int_n) |-> ##[1:5] status_word[11])
        else $error("pin fall flag not set in time");
    a_supply_level: assert property (1'b1 |=> status_word[10] == $past(supply_low))
        else $error("low supply flag does not follow input");
    a_afc_toggle: assert property (afc_done |=> status_word[5] != $past(status_word[5]))
        else $error("correction toggle did not flip");
    a_offset_follow: assert property (1'b1 |=> status_word[4:0] ==
        $past({offset_sign_in, offset_magnitude_in}))
        else $error("offset field does not follow input");
    a_sdo_idle_low: assert property (spi_cs_n |-> !spi_sdo_oe && !spi_sdo)
        else $error("serial output driven while deselected");
    a_tx_load_single: assert property (tx_byte_load |=> !tx_byte_load)
        else $error("tx byte strobe longer than one cycle");
endmodule
bind transceiver_command_register_bank transceiver_command_register_bank_checker i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .ext_int_n(ext_int_n), .txrx_event(txrx_event),
    .overrun_event(overrun_event), .wake_event(wake_event), .afc_done(afc_done),
    .supply_low(supply_low), .offset_sign_in(offset_sign_in),
    .offset_magnitude_in(offset_magnitude_in), .status_word(status_word),
    .band_select(band_select), .band_valid(band_valid),
    .crystal_load_select(crystal_load_select), .crystal_load_tenths(crystal_load_tenths),
    .rx_buffer_enable(rx_buffer_enable), .data_pin_oe(data_pin_oe),
    .data_pin_out(data_pin_out), .tx_byte_load(tx_byte_load));

// ### bench/xcvr_spi_host.sv
/*
 * Host model: word-wide serial master making its own 12 ns clock in frames.
 * Assumes the bench calls xfer once at a time.
 */
`timescale 1ns/1ps
module xcvr_spi_host (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    // idle: clock parked low, select high
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end
    // one frame, msb first; sdo taken at each rising edge before it moves
    task automatic xfer(input int n, input logic [16:0] w, output logic [16:0] got);
        got = '0;
        spi_cs_n = 1'b0;
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            spi_sdi = w[i];
            #6;
            got = {got[15:0], spi_sdo};
            spi_sck = 1'b1;
            #6;
            spi_sck = 1'b0;
        end
        #7;
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi; // released line must not keep its last level
        #50;
    endtask
endmodule

// ### verilog/transceiver_command_register_bank.sv
/*
 * Command and register bank of the radio: serial word link on its own
 * clock, write decode into the register words, sticky status flags and
 * the status shift-out.
 * Assumes the serial clock stops outside frames, chip select goes high
 * between words, and event inputs are one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
`include "xcvr_consts.svh"

module transceiver_command_register_bank (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic ext_int_n,
    input wire logic txrx_event,
    input wire logic overrun_event,
    input wire logic wake_event,
    input wire logic afc_done,
    input wire logic supply_low,
    input wire logic rx_empty,
    input wire logic signal_level,
    input wire logic good_quality,
    input wire logic clock_lock,
    input wire logic offset_sign_in,
    input wire logic [3:0] offset_magnitude_in,
    input wire logic rx_data_raw,
    input wire logic rx_clk_raw,
    output logic [15:0] status_word,
    output logic tx_data_path_enable,
    output logic rx_buffer_enable,
    output logic [1:0] band_select,
    output logic band_valid,
    output logic [3:0] crystal_load_select,
    output logic [7:0] crystal_load_tenths,
    output logic [15:0] freq_offset_adjust,
    output logic [15:0] transmit_modulation_setup,
    output logic [15:0] transmit_byte_write,
    output logic [15:0] carrier_frequency_word,
    output logic [15:0] receiver_control,
    output logic [15:0] baseband_filter_setup,
    output logic [15:0] buffer_and_reset_setup,
    output logic [15:0] sync_pattern_byte,
    output logic [15:0] bit_rate_setup,
    output logic [15:0] power_block_enables,
    output logic [15:0] wake_timer_period,
    output logic [15:0] wake_duty_cycle,
    output logic [15:0] supply_threshold_clock_div,
    output logic [15:0] synthesizer_setup,
    output logic tx_byte_load,
    output logic rx_buffer_read,
    output logic data_pin_out,
    output logic data_pin_oe,
    output logic rclk_pin_out,
    output logic rclk_pin_oe
);

    // system clock state
    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic int_meta;
        logic int_sync;
        logic int_prev;
        xcvr_pkg::status_t flags;
        logic [15:0] shadow;
        logic [`REG_COUNT-1:0][15:0] regs;
        logic tx_byte_load;
        logic rx_buffer_read;
        logic data_out;
        logic data_oe;
        logic rclk_out;
        logic rclk_oe;
        logic [7:0] cap_tenths;
        logic band_valid;
    } sys_state_t;

    // link control, cleared while chip select is high
    typedef struct packed {
        logic in_frame;
        logic reading;
        logic done;
        logic sdo;
        logic sdo_oe;
        logic [3:0] idx;
    } link_ctl_t;

    // link word, kept after the frame so the system side can pick it up
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] count;
        logic first_bit;
    } link_word_t;

    // register words, index 0 lowest
    localparam logic [`REG_COUNT-1:0][15:0] RST_WORDS = {
        `RST_SYNTH, `RST_SUPPLY, `RST_DUTY, `RST_WAKE, `RST_POWER,
        `RST_RATE, `RST_SYNC, `RST_BUFRST, `RST_BBAND, `RST_RXCTL,
        `RST_FREQ, `RST_TXBYTE, `RST_TXMOD, `RST_AFADJ, `RST_CONFIG
    };
    localparam logic [`REG_COUNT-1:0][15:0] MSK_WORDS = {
        `MSK_SYNTH, `MSK_SUPPLY, `MSK_DUTY, `MSK_WAKE, `MSK_POWER,
        `MSK_RATE, `MSK_SYNC, `MSK_BUFRST, `MSK_BBAND, `MSK_RXCTL,
        `MSK_FREQ, `MSK_TXBYTE, `MSK_TXMOD, `MSK_AFADJ, `MSK_CONFIG
    };

    // power-on values
    localparam xcvr_pkg::status_t POR_FLAGS = '{power_on_flag: 1'b1, default: '0};
    localparam xcvr_pkg::config_t CFG_INIT = `RST_CONFIG;
    localparam logic [7:0] CAP_INIT =
        8'(`CAP_BASE_TENTHS + {4'h0, CFG_INIT.crystal_load_select} * `CAP_STEP_TENTHS);
    localparam sys_state_t SYS_INIT = '{
        cs_meta: 1'b1,
        cs_sync: 1'b1,
        cs_prev: 1'b1,
        int_meta: 1'b1,
        int_sync: 1'b1,
        int_prev: 1'b1,
        flags: POR_FLAGS,
        shadow: POR_FLAGS,
        regs: RST_WORDS,
        cap_tenths: CAP_INIT,
        data_oe: ~CFG_INIT.rx_buffer_enable,
        rclk_oe: ~CFG_INIT.rx_buffer_enable,
        band_valid: (CFG_INIT.band_select != 2'h0),
        default: '0
    };

    sys_state_t s_reg;
    sys_state_t s_next;
    link_ctl_t l_reg;
    link_ctl_t l_next;
    link_word_t w_reg;
    link_word_t w_next;
    xcvr_pkg::config_t cfg_next;

    // link side: bits are taken on the rising serial clock edge
    always_comb begin
        l_next = l_reg;
        w_next = w_reg;
        if (!l_reg.in_frame) begin
            // first edge of a frame, the leading bit tells read from write
            l_next.in_frame = 1'b1;
            w_next.shift = {15'h0000, spi_sdi};
            w_next.count = 5'h01;
            w_next.first_bit = spi_sdi;
            if (!spi_sdi) begin
                l_next.reading = 1'b1;
                l_next.sdo_oe = 1'b1;
                l_next.sdo = s_reg.shadow[15];
                l_next.idx = 4'hE;
            end
        end else begin
            w_next.shift = {w_reg.shift[14:0], spi_sdi};
            // saturate one past a word so long frames stay recognisable
            if (w_reg.count <= `WORD_BITS) begin
                w_next.count = w_reg.count + 5'h01;
            end
            if (l_reg.reading) begin
                // status bits follow msb first, zeros after bit 0
                l_next.sdo = l_reg.done ? 1'b0 : s_reg.shadow[l_reg.idx];
                l_next.done = l_reg.done | (l_reg.idx == 4'h0);
                l_next.idx = l_reg.idx - 4'h1;
            end
        end
    end

    // control part is held clear while the host has the chip deselected
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // word part has no reset: only read after a frame has filled it
    always_ff @(posedge spi_sck) begin
        w_reg <= w_next;
    end

    // system side: frame end, decode, flags and derived outputs
    always_comb begin
        logic frame_end;
        logic word_ok;
        logic hit;
        frame_end = 1'b0;
        word_ok = 1'b0;
        hit = 1'b0;
        s_next = s_reg;
        cfg_next = '0;

        // two-stage synchronisers for the pins
        s_next.cs_meta = spi_cs_n;
        s_next.cs_sync = s_reg.cs_meta;
        s_next.cs_prev = s_reg.cs_sync;
        s_next.int_meta = ext_int_n;
        s_next.int_sync = s_reg.int_meta;
        s_next.int_prev = s_reg.int_sync;
        s_next.tx_byte_load = 1'b0;
        s_next.rx_buffer_read = 1'b0;

        // word is stable here: the serial clock has stopped with select high
        frame_end = s_reg.cs_sync & ~s_reg.cs_prev;

        // a status read clears the read-to-clear flags
        if (frame_end && w_reg.count != 5'h00 && !w_reg.first_bit) begin
            s_next.flags.power_on_flag = 1'b0;
            s_next.flags.buffer_overrun_flag = 1'b0;
            s_next.flags.wake_timer_flag = 1'b0;
            s_next.flags.ext_pin_fall_flag = 1'b0;
        end

        // writes need exactly one whole word with a leading one
        word_ok = frame_end && w_reg.first_bit && (w_reg.count == `WORD_BITS);
        if (word_ok) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                if ((w_reg.shift & MSK_WORDS[i]) == (RST_WORDS[i] & MSK_WORDS[i])) begin
                    s_next.regs[i] = w_reg.shift;
                    hit = 1'b1;
                end
            end
            if (hit && (w_reg.shift & `MSK_TXBYTE) == (`RST_TXBYTE & `MSK_TXBYTE)) begin
                s_next.tx_byte_load = 1'b1;
            end
            // buffer read command is not stored, it only pops and clears
            if ((w_reg.shift & `MSK_RXREAD) == (`RST_RXREAD & `MSK_RXREAD)) begin
                s_next.rx_buffer_read = 1'b1;
                s_next.flags.tx_ready_rx_level_flag = 1'b0;
            end
            // unmatched codes fall through with every word left alone
        end

        // sticky sets come after the clears so a coincident event wins
        if (txrx_event) begin
            s_next.flags.tx_ready_rx_level_flag = 1'b1;
        end
        if (overrun_event) begin
            s_next.flags.buffer_overrun_flag = 1'b1;
        end
        if (wake_event) begin
            s_next.flags.wake_timer_flag = 1'b1;
        end
        if (s_reg.int_prev && !s_reg.int_sync) begin
            s_next.flags.ext_pin_fall_flag = 1'b1;
        end
        if (afc_done) begin
            s_next.flags.offset_cycle_toggle = ~s_reg.flags.offset_cycle_toggle;
        end

        // live levels, registered once
        s_next.flags.low_supply_flag = supply_low;
        s_next.flags.rx_buffer_empty_flag = rx_empty;
        s_next.flags.signal_level_flag = signal_level;
        s_next.flags.good_quality_flag = good_quality;
        s_next.flags.clock_recovery_lock_flag = clock_lock;
        s_next.flags.offset_sign = offset_sign_in;
        s_next.flags.offset_magnitude = offset_magnitude_in;

        // snapshot frozen while selected, so the link reads a still word
        if (s_reg.cs_sync) begin
            s_next.shadow = s_reg.flags;
        end

        // configuration word decoded into its fields
        cfg_next = s_next.regs[`IDX_CONFIG];
        s_next.band_valid = (cfg_next.band_select != 2'h0);
        s_next.cap_tenths = 8'(`CAP_BASE_TENTHS
            + {4'h0, cfg_next.crystal_load_select} * `CAP_STEP_TENTHS);

        // without the rx buffer, raw data and clock go out on pins
        s_next.data_oe = ~cfg_next.rx_buffer_enable;
        s_next.rclk_oe = ~cfg_next.rx_buffer_enable;
        s_next.data_out = ~cfg_next.rx_buffer_enable & rx_data_raw;
        s_next.rclk_out = ~cfg_next.rx_buffer_enable & rx_clk_raw;
    end

    // system state register, reset loads the power-on words
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_reg <= SYS_INIT;
        end else begin
            s_reg <= s_next;
        end
    end

    // link outputs
    assign spi_sdo = l_reg.sdo;
    assign spi_sdo_oe = l_reg.sdo_oe;

    // status and configuration fields
    assign status_word = s_reg.flags;
    assign tx_data_path_enable = s_reg.regs[`IDX_CONFIG][7];
    assign rx_buffer_enable = s_reg.regs[`IDX_CONFIG][6];
    assign band_select = s_reg.regs[`IDX_CONFIG][5:4];
    assign band_valid = s_reg.band_valid;
    assign crystal_load_select = s_reg.regs[`IDX_CONFIG][3:0];
    assign crystal_load_tenths = s_reg.cap_tenths;

    // remaining register words, whole
    assign freq_offset_adjust = s_reg.regs[1];
    assign transmit_modulation_setup = s_reg.regs[2];
    assign transmit_byte_write = s_reg.regs[`IDX_TXBYTE];
    assign carrier_frequency_word = s_reg.regs[4];
    assign receiver_control = s_reg.regs[5];
    assign baseband_filter_setup = s_reg.regs[6];
    assign buffer_and_reset_setup = s_reg.regs[7];
    assign sync_pattern_byte = s_reg.regs[8];
    assign bit_rate_setup = s_reg.regs[9];
    assign power_block_enables = s_reg.regs[10];
    assign wake_timer_period = s_reg.regs[11];
    assign wake_duty_cycle = s_reg.regs[12];
    assign supply_threshold_clock_div = s_reg.regs[13];
    assign synthesizer_setup = s_reg.regs[14];

    // strobes and pin drives
    assign tx_byte_load = s_reg.tx_byte_load;
    assign rx_buffer_read = s_reg.rx_buffer_read;
    assign data_pin_out = s_reg.data_out;
    assign data_pin_oe = s_reg.data_oe;
    assign rclk_pin_out = s_reg.rclk_out;
    assign rclk_pin_oe = s_reg.rclk_oe;

endmodule

// ### verilog/xcvr_consts.svh
/*
 * Constants of the transceiver command register bank: power-on words,
 * command masks, word length and crystal load scale.
 * Assumes it is included by the design file and by the bench.
 */
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH
`define WORD_BITS 5'd16
`define REG_COUNT 15
`define RST_CONFIG 16'h8008
`define MSK_CONFIG 16'hFF00
`define RST_AFADJ 16'hC4F7
`define MSK_AFADJ 16'hFF00
`define RST_TXMOD 16'h9800
`define MSK_TXMOD 16'hFE00
`define RST_TXBYTE 16'hB8AA
`define MSK_TXBYTE 16'hFF00
`define RST_FREQ 16'hA680
`define MSK_FREQ 16'hF000
`define RST_RXCTL 16'h9080
`define MSK_RXCTL 16'hF800
`define RST_BBAND 16'hC22C
`define MSK_BBAND 16'hFF00
`define RST_BUFRST 16'hCA80
`define MSK_BUFRST 16'hFF00
`define RST_SYNC 16'hCED4
`define MSK_SYNC 16'hFF00
`define RST_RATE 16'hC623
`define MSK_RATE 16'hFF00
`define RST_POWER 16'h8208
`define MSK_POWER 16'hFF00
`define RST_WAKE 16'hE196
`define MSK_WAKE 16'hE000
`define RST_DUTY 16'hC80E
`define MSK_DUTY 16'hFF00
`define RST_SUPPLY 16'hC000
`define MSK_SUPPLY 16'hFF00
`define RST_SYNTH 16'hCC67
`define MSK_SYNTH 16'hFF00
`define RST_RXREAD 16'hB000
`define MSK_RXREAD 16'hFF00
`define IDX_CONFIG 0
`define IDX_TXBYTE 3
`define CAP_BASE_TENTHS 8'h55
`define CAP_STEP_TENTHS 8'h05
`endif

// ### verilog/xcvr_pkg.sv
/*
 * Types of the transceiver command register bank: status word and
 * configuration word layouts.
 * Assumes nothing of its surroundings.
 */
package xcvr_pkg;
    // status word, bit 15 first
    typedef struct packed {
        logic tx_ready_rx_level_flag;
        logic power_on_flag;
        logic buffer_overrun_flag;
        logic wake_timer_flag;
        logic ext_pin_fall_flag;
        logic low_supply_flag;
        logic rx_buffer_empty_flag;
        logic signal_level_flag;
        logic good_quality_flag;
        logic clock_recovery_lock_flag;
        logic offset_cycle_toggle;
        logic offset_sign;
        logic [3:0] offset_magnitude;
    } status_t;
    // band and buffer configuration word
    typedef struct packed {
        logic [7:0] command_code;
        logic tx_data_path_enable;
        logic rx_buffer_enable;
        logic [1:0] band_select;
        logic [3:0] crystal_load_select;
    } config_t;
endpackage
